// [design/pmw_consts.svh]
// Offsets, field positions, reset values and timing counts of the bus link.
`ifndef PMW_CONSTS_SVH
`define PMW_CONSTS_SVH

`define PMW_CMD_CFG_WR 4'hb
`define PMW_CMD_MEM_WR 4'h7
`define PMW_PMCTRL_IDX 6'h12
`define PMW_PMCTRL_RST 32'h0000_0000
`define PMW_PMCTRL_MASK 32'h0006_0000
`define PMW_WAKE_EN_BIT 18
`define PMW_WAKE_SEL_BIT 17
`define PMW_CLK_PERIOD_NS 25
`define PMW_BUS_CLK_MIN_MHZ 20
`define PMW_BUS_CLK_MAX_MHZ 33
`define PMW_RST_HOLD_NS 100000
`define PMW_RST_HOLD_CYC \
  ((`PMW_RST_HOLD_NS + `PMW_CLK_PERIOD_NS - 1) / `PMW_CLK_PERIOD_NS)
`define PMW_WAKE_PULSE_CYC 16

`endif

// [design/pmw_pkg.sv]
// Types shared by both ends of the bus link.
package pmw_pkg;

  typedef logic [31:0] pmw_word_t;
  typedef logic [3:0] pmw_nib_t;

  typedef enum logic [2:0] {
    DEV_IDLE = 3'h0,
    DEV_REQ = 3'h1,
    DEV_ADDR = 3'h2,
    DEV_DATA = 3'h3,
    DEV_TURN = 3'h4
  } pmw_dev_state_t;

  typedef enum logic [2:0] {
    HST_RST = 3'h0,
    HST_IDLE = 3'h1,
    HST_ADDR = 3'h2,
    HST_DATA = 3'h3,
    HST_TURN = 3'h4
  } pmw_host_state_t;

endpackage

// [design/pmw_bus_if.sv]
// Bus wires between the device end and the host bridge with its arbiter.
`timescale 1ns/10ps
`default_nettype none

interface pmw_bus_if;
  import pmw_pkg::*;

  logic bus_rst;
  logic idsel;
  logic gnt_n;
  logic dev_req_o;
  logic dev_req_oe;
  logic dev_frame_o;
  logic dev_frame_oe;
  logic dev_irdy_o;
  logic dev_irdy_oe;
  pmw_word_t dev_ad_o;
  logic dev_ad_oe;
  pmw_nib_t dev_cbe_o;
  logic dev_cbe_oe;
  logic dev_pme_oe;
  logic host_frame_o;
  logic host_frame_oe;
  logic host_irdy_o;
  logic host_irdy_oe;
  pmw_word_t host_ad_o;
  logic host_ad_oe;
  pmw_nib_t host_cbe_o;
  logic host_cbe_oe;
  logic req_n;
  logic frame_n;
  logic irdy_n;
  pmw_word_t ad;
  pmw_nib_t cbe;
  logic pme_n;

  // Undriven lines settle high, as the board pull-ups would make them.
  assign req_n = dev_req_oe ? dev_req_o : 1'b1;
  assign frame_n = dev_frame_oe ? dev_frame_o :
                   (host_frame_oe ? host_frame_o : 1'b1);
  assign irdy_n = dev_irdy_oe ? dev_irdy_o :
                  (host_irdy_oe ? host_irdy_o : 1'b1);
  assign ad = dev_ad_oe ? dev_ad_o :
              (host_ad_oe ? host_ad_o : 32'hffff_ffff);
  assign cbe = dev_cbe_oe ? dev_cbe_o :
               (host_cbe_oe ? host_cbe_o : 4'hf);
  assign pme_n = dev_pme_oe ? 1'b0 : 1'b1;

  modport device (
    input bus_rst, idsel, gnt_n, frame_n, irdy_n, ad, cbe,
    output dev_req_o, dev_req_oe, dev_frame_o, dev_frame_oe,
    output dev_irdy_o, dev_irdy_oe, dev_ad_o, dev_ad_oe,
    output dev_cbe_o, dev_cbe_oe, dev_pme_oe
  );

  modport host (
    input req_n, frame_n, irdy_n, ad, cbe, pme_n, dev_frame_oe,
    output bus_rst, idsel, gnt_n, host_frame_o, host_frame_oe,
    output host_irdy_o, host_irdy_oe, host_ad_o, host_ad_oe,
    output host_cbe_o, host_cbe_oe
  );

endinterface

`default_nettype wire

// [design/pmw_device.sv]
// Device end: bus master write path, configuration claim and wake event pin.
//
// What this block does
// - Request the bus while a master transfer pends.
// - Start a master transaction only when granted.
// - Event pin only pulls low or floats.
// - Pull event pin low on any event.
// - Enable bit 18 selects wake-on-network mode.
// - Wake frame in that mode raises event.
// - Bit 17 picks first or second wake protocol.
// - Host marks configuration cycles with select input.
// - Master holds frame low through its tenure.
// - Data phase completes only with initiator ready.
// - Address then data share the same lines.
// - Command in address, byte enables in data.
// - Everything moves on the rising clock edge.
// - Reset held long; all outputs float meanwhile.
`timescale 1ns/10ps
`default_nettype none
`include "pmw_consts.svh"

module pmw_device (
  input wire logic core_clk,
  input wire logic reset,
  pmw_bus_if.device bus,
  input wire logic xfer_start,
  input wire pmw_pkg::pmw_word_t xfer_addr,
  input wire pmw_pkg::pmw_word_t xfer_data,
  input wire pmw_pkg::pmw_nib_t xfer_cmd,
  input wire pmw_pkg::pmw_nib_t xfer_be,
  output logic xfer_busy,
  output logic xfer_done,
  input wire logic pm_event,
  input wire logic wake_frame_valid,
  input wire logic pme_clear,
  output pmw_pkg::pmw_word_t power_mgmt_control_register,
  output logic pme_status,
  output logic network_wake_signal
);
  import pmw_pkg::*;

  // ------------------------------------------------------------
  // Merge of a configuration write into the control register
  // ------------------------------------------------------------
  function automatic pmw_word_t merge_bytes(input pmw_word_t old_val,
                                            input pmw_word_t new_val,
                                            input pmw_nib_t be_n);
    pmw_word_t res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (!be_n[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return (res & `PMW_PMCTRL_MASK) | (old_val & ~`PMW_PMCTRL_MASK);
  endfunction

  logic rst_int;
  pmw_dev_state_t state;
  pmw_dev_state_t next_state;
  pmw_word_t lat_addr;
  pmw_word_t next_lat_addr;
  pmw_word_t lat_data;
  pmw_word_t next_lat_data;
  pmw_nib_t lat_cmd;
  pmw_nib_t next_lat_cmd;
  pmw_nib_t lat_be;
  pmw_nib_t next_lat_be;
  logic req_o;
  logic next_req_o;
  logic req_oe;
  logic next_req_oe;
  logic frame_o;
  logic next_frame_o;
  logic irdy_o;
  logic next_irdy_o;
  logic drive;
  logic next_drive;
  pmw_word_t ad_o;
  pmw_word_t next_ad_o;
  pmw_nib_t cbe_o;
  pmw_nib_t next_cbe_o;
  logic done;
  logic next_done;

  // A bus reset from the host resets the device as well as its own reset.
  assign rst_int = reset | bus.bus_rst;

  // ------------------------------------------------------------
  // Master sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_lat_addr = lat_addr;
    next_lat_data = lat_data;
    next_lat_cmd = lat_cmd;
    next_lat_be = lat_be;
    next_req_o = req_o;
    next_req_oe = 1'b1;
    next_frame_o = frame_o;
    next_irdy_o = irdy_o;
    next_drive = drive;
    next_ad_o = ad_o;
    next_cbe_o = cbe_o;
    next_done = 1'b0;
    case (state)
      DEV_IDLE: begin
        if (xfer_start) begin
          next_lat_addr = xfer_addr;
          next_lat_data = xfer_data;
          next_lat_cmd = xfer_cmd;
          next_lat_be = xfer_be;
          next_req_o = 1'b0;
          next_state = DEV_REQ;
        end
      end
      DEV_REQ: begin
        // The previous owner gets its turnaround before we drive.
        if (!bus.gnt_n && bus.frame_n && bus.irdy_n) begin
          next_req_o = 1'b1;
          next_drive = 1'b1;
          next_frame_o = 1'b0;
          next_irdy_o = 1'b1;
          next_ad_o = lat_addr;
          next_cbe_o = lat_cmd;
          next_state = DEV_ADDR;
        end
      end
      DEV_ADDR: begin
        next_frame_o = 1'b0;
        next_irdy_o = 1'b0;
        next_ad_o = lat_data;
        next_cbe_o = lat_be;
        next_state = DEV_DATA;
      end
      DEV_DATA: begin
        // The data phase ends here because initiator ready is low.
        next_frame_o = 1'b1;
        next_irdy_o = 1'b1;
        next_state = DEV_TURN;
      end
      DEV_TURN: begin
        next_drive = 1'b0;
        next_done = 1'b1;
        next_state = DEV_IDLE;
      end
      default: begin
        next_drive = 1'b0;
        next_req_o = 1'b1;
        next_state = DEV_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst_int) begin
      state <= DEV_IDLE;
      lat_addr <= 32'h0000_0000;
      lat_data <= 32'h0000_0000;
      lat_cmd <= 4'h0;
      lat_be <= 4'hf;
      req_o <= 1'b1;
      req_oe <= 1'b0;
      frame_o <= 1'b1;
      irdy_o <= 1'b1;
      drive <= 1'b0;
      ad_o <= 32'h0000_0000;
      cbe_o <= 4'h0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      lat_addr <= next_lat_addr;
      lat_data <= next_lat_data;
      lat_cmd <= next_lat_cmd;
      lat_be <= next_lat_be;
      req_o <= next_req_o;
      req_oe <= next_req_oe;
      frame_o <= next_frame_o;
      irdy_o <= next_irdy_o;
      drive <= next_drive;
      ad_o <= next_ad_o;
      cbe_o <= next_cbe_o;
      done <= next_done;
    end
  end

  assign bus.dev_req_o = req_o;
  assign bus.dev_req_oe = req_oe;
  assign bus.dev_frame_o = frame_o;
  assign bus.dev_frame_oe = drive;
  assign bus.dev_irdy_o = irdy_o;
  assign bus.dev_irdy_oe = drive;
  assign bus.dev_ad_o = ad_o;
  assign bus.dev_ad_oe = drive;
  assign bus.dev_cbe_o = cbe_o;
  assign bus.dev_cbe_oe = drive;
  assign xfer_busy = (state != DEV_IDLE);
  assign xfer_done = done;

  // ------------------------------------------------------------
  // Configuration claim and wake event logic
  // ------------------------------------------------------------
  logic frame_seen;
  logic next_frame_seen;
  logic cfg_hit;
  logic next_cfg_hit;
  pmw_word_t next_pmctrl;
  logic next_pme_status;
  logic wake_hit;
  logic [7:0] wake_cnt;
  logic [7:0] next_wake_cnt;
  logic next_wake;

  // Only the two mode bits are writable; a narrow claim keeps a stray
  // configuration access from disturbing anything else.
  always_comb begin
    next_frame_seen = ~bus.frame_n;
    next_cfg_hit = cfg_hit;
    next_pmctrl = power_mgmt_control_register;
    if (!drive && !bus.frame_n && !frame_seen) begin
      next_cfg_hit = bus.idsel && (bus.cbe == `PMW_CMD_CFG_WR) &&
                     (bus.ad[7:2] == `PMW_PMCTRL_IDX);
    end else if (cfg_hit && !bus.irdy_n) begin
      next_pmctrl = merge_bytes(power_mgmt_control_register, bus.ad,
                                bus.cbe);
      next_cfg_hit = 1'b0;
    end else if (bus.frame_n && bus.irdy_n) begin
      next_cfg_hit = 1'b0;
    end
  end

  assign wake_hit = wake_frame_valid &&
                    power_mgmt_control_register[`PMW_WAKE_EN_BIT];

  // A new event in the cycle of a clear keeps the status set.
  always_comb begin
    next_pme_status = (pme_status & ~pme_clear) | pm_event | wake_hit;
    next_wake_cnt = wake_cnt;
    next_wake = 1'b0;
    if (power_mgmt_control_register[`PMW_WAKE_SEL_BIT]) begin
      next_wake = network_wake_signal & ~pme_clear;
      if (wake_hit) begin
        next_wake = 1'b1;
      end
      next_wake_cnt = 8'h00;
    end else begin
      if (wake_hit) begin
        next_wake_cnt = 8'(`PMW_WAKE_PULSE_CYC);
      end else if (wake_cnt != 8'h00) begin
        next_wake_cnt = wake_cnt - 8'h01;
      end
      next_wake = (next_wake_cnt != 8'h00);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_int) begin
      frame_seen <= 1'b0;
      cfg_hit <= 1'b0;
      power_mgmt_control_register <= `PMW_PMCTRL_RST;
      pme_status <= 1'b0;
      wake_cnt <= 8'h00;
      network_wake_signal <= 1'b0;
    end else begin
      frame_seen <= next_frame_seen;
      cfg_hit <= next_cfg_hit;
      power_mgmt_control_register <= next_pmctrl;
      pme_status <= next_pme_status;
      wake_cnt <= next_wake_cnt;
      network_wake_signal <= next_wake;
    end
  end

  // The pin has an enable only: it is pulled low or left floating.
  assign bus.dev_pme_oe = pme_status;

endmodule

`default_nettype wire

// [design/pmw_host.sv]
// Host end: bus reset, arbiter, configuration writer and write target.
`timescale 1ns/10ps
`default_nettype none
`include "pmw_consts.svh"

module pmw_host (
  input wire logic core_clk,
  input wire logic reset,
  pmw_bus_if.host bus,
  input wire logic cfg_start,
  input wire logic cfg_sel,
  input wire pmw_pkg::pmw_word_t cfg_addr,
  input wire pmw_pkg::pmw_word_t cfg_data,
  input wire pmw_pkg::pmw_nib_t cfg_be,
  output logic cfg_busy,
  output logic cfg_done,
  output logic tgt_valid,
  output pmw_pkg::pmw_word_t tgt_addr,
  output pmw_pkg::pmw_nib_t tgt_cmd,
  output pmw_pkg::pmw_word_t tgt_data,
  output pmw_pkg::pmw_nib_t tgt_be,
  output logic pme_seen
);
  import pmw_pkg::*;

  pmw_host_state_t state;
  pmw_host_state_t next_state;
  logic [11:0] rst_cnt;
  logic [11:0] next_rst_cnt;
  logic pend;
  logic next_pend;
  logic gnt_n;
  logic next_gnt_n;
  logic idsel;
  logic next_idsel;
  logic drive;
  logic next_drive;
  logic frame_o;
  logic next_frame_o;
  logic irdy_o;
  logic next_irdy_o;
  pmw_word_t ad_o;
  pmw_word_t next_ad_o;
  pmw_nib_t cbe_o;
  pmw_nib_t next_cbe_o;
  logic done;
  logic next_done;
  logic sel;
  logic next_sel;
  logic bus_idle;

  assign bus_idle = bus.frame_n & bus.irdy_n;

  // ------------------------------------------------------------
  // Reset stretch, arbiter and configuration master
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_rst_cnt = rst_cnt;
    next_pend = pend | cfg_start;
    next_sel = cfg_start ? cfg_sel : sel;
    next_gnt_n = 1'b1;
    next_idsel = 1'b0;
    next_drive = drive;
    next_frame_o = frame_o;
    next_irdy_o = irdy_o;
    next_ad_o = ad_o;
    next_cbe_o = cbe_o;
    next_done = 1'b0;
    case (state)
      HST_RST: begin
        next_rst_cnt = rst_cnt + 12'h001;
        if (rst_cnt == 12'(`PMW_RST_HOLD_CYC - 1)) begin
          next_state = HST_IDLE;
        end
      end
      HST_IDLE: begin
        // Its own pending access keeps the grant away from the device.
        next_gnt_n = !((!bus.req_n) && !pend);
        if (pend && gnt_n && bus_idle) begin
          next_pend = cfg_start;
          next_drive = 1'b1;
          next_frame_o = 1'b0;
          next_irdy_o = 1'b1;
          next_ad_o = cfg_addr;
          next_cbe_o = `PMW_CMD_CFG_WR;
          next_idsel = sel;
          next_state = HST_ADDR;
        end
      end
      HST_ADDR: begin
        next_irdy_o = 1'b0;
        next_ad_o = cfg_data;
        next_cbe_o = cfg_be;
        next_state = HST_DATA;
      end
      HST_DATA: begin
        next_frame_o = 1'b1;
        next_irdy_o = 1'b1;
        next_state = HST_TURN;
      end
      HST_TURN: begin
        next_drive = 1'b0;
        next_done = 1'b1;
        next_state = HST_IDLE;
      end
      default: begin
        next_drive = 1'b0;
        next_state = HST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= HST_RST;
      rst_cnt <= 12'h000;
      pend <= 1'b0;
      sel <= 1'b0;
      gnt_n <= 1'b1;
      idsel <= 1'b0;
      drive <= 1'b0;
      frame_o <= 1'b1;
      irdy_o <= 1'b1;
      ad_o <= 32'h0000_0000;
      cbe_o <= 4'h0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      rst_cnt <= next_rst_cnt;
      pend <= next_pend;
      sel <= next_sel;
      gnt_n <= next_gnt_n;
      idsel <= next_idsel;
      drive <= next_drive;
      frame_o <= next_frame_o;
      irdy_o <= next_irdy_o;
      ad_o <= next_ad_o;
      cbe_o <= next_cbe_o;
      done <= next_done;
    end
  end

  assign bus.bus_rst = (state == HST_RST);
  assign bus.gnt_n = gnt_n;
  assign bus.idsel = idsel;
  assign bus.host_frame_o = frame_o;
  assign bus.host_frame_oe = drive;
  assign bus.host_irdy_o = irdy_o;
  assign bus.host_irdy_oe = drive;
  assign bus.host_ad_o = ad_o;
  assign bus.host_ad_oe = drive;
  assign bus.host_cbe_o = cbe_o;
  assign bus.host_cbe_oe = drive;
  assign cfg_busy = pend | (state != HST_IDLE);
  assign cfg_done = done;

  // ------------------------------------------------------------
  // Target side for device writes
  // ------------------------------------------------------------
  logic armed;
  logic next_armed;
  logic next_tgt_valid;
  pmw_word_t next_tgt_addr;
  pmw_nib_t next_tgt_cmd;
  pmw_word_t next_tgt_data;
  pmw_nib_t next_tgt_be;

  always_comb begin
    next_armed = armed;
    next_tgt_valid = 1'b0;
    next_tgt_addr = tgt_addr;
    next_tgt_cmd = tgt_cmd;
    next_tgt_data = tgt_data;
    next_tgt_be = tgt_be;
    if (bus.dev_frame_oe && !bus.frame_n && bus.irdy_n && !armed) begin
      next_armed = 1'b1;
      next_tgt_addr = bus.ad;
      next_tgt_cmd = bus.cbe;
    end else if (armed && !bus.irdy_n) begin
      next_armed = 1'b0;
      next_tgt_valid = 1'b1;
      next_tgt_data = bus.ad;
      next_tgt_be = bus.cbe;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      armed <= 1'b0;
      tgt_valid <= 1'b0;
      tgt_addr <= 32'h0000_0000;
      tgt_cmd <= 4'h0;
      tgt_data <= 32'h0000_0000;
      tgt_be <= 4'hf;
      pme_seen <= 1'b0;
    end else begin
      armed <= next_armed;
      tgt_valid <= next_tgt_valid;
      tgt_addr <= next_tgt_addr;
      tgt_cmd <= next_tgt_cmd;
      tgt_data <= next_tgt_data;
      tgt_be <= next_tgt_be;
      pme_seen <= ~bus.pme_n;
    end
  end

endmodule

`default_nettype wire

// [testbench/pmw_bus_sva.sv]
// Concurrent checks on the bus wires between the device and host ends.
`timescale 1ns/10ps
`default_nettype none
`include "pmw_consts.svh"

module pmw_bus_sva (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic bus_rst,
  input wire logic idsel,
  input wire logic gnt_n,
  input wire logic req_n,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire pmw_pkg::pmw_nib_t cbe,
  input wire logic pme_n,
  input wire logic dev_req_oe,
  input wire logic dev_frame_oe,
  input wire logic dev_irdy_oe,
  input wire logic dev_ad_oe,
  input wire logic dev_cbe_oe,
  input wire logic dev_pme_oe,
  input wire logic host_frame_oe,
  input wire logic host_ad_oe
);
  import pmw_pkg::*;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_req_hold: assert property ($rose(dev_frame_oe) |->
    $past(req_n) == 1'b0)
    else $error("bus taken without a request");
  a_req_wait: assert property (!req_n && gnt_n && !bus_rst |=> !req_n)
    else $error("request dropped before grant");
  a_grant_owns: assert property ($rose(dev_frame_oe) |->
    $past(gnt_n) == 1'b0 && $past(frame_n) && $past(irdy_n))
    else $error("bus taken without grant on idle bus");
  a_gnt_drop: assert property ($rose(req_n) |=> gnt_n)
    else $error("grant kept after request released");
  a_idsel_addr: assert property (idsel |->
    host_frame_oe && !frame_n && irdy_n)
    else $error("select outside configuration address phase");
  a_frame_tenure: assert property ($rose(dev_frame_oe) |->
    !frame_n [*2] ##1 (frame_n && dev_frame_oe) ##1 !dev_frame_oe)
    else $error("frame not held through tenure");
  a_irdy_data: assert property ($rose(dev_irdy_oe) |->
    irdy_n ##1 !irdy_n ##1 irdy_n ##1 !dev_irdy_oe)
    else $error("initiator ready outside data phase");
  a_no_clash: assert property (!(dev_ad_oe && host_ad_oe))
    else $error("both ends drive address data lines");
  a_cfg_cmd: assert property (idsel |-> cbe == `PMW_CMD_CFG_WR)
    else $error("wrong command in configuration address phase");
  a_rst_float: assert property (bus_rst |-> !(dev_req_oe ||
    dev_frame_oe || dev_irdy_oe || dev_ad_oe || dev_cbe_oe || dev_pme_oe))
    else $error("device drives a pin during bus reset");
  a_req_release: assert property ($rose(dev_frame_oe) |-> req_n)
    else $error("request kept into address phase");

  c_dev_tenure: cover property ($rose(dev_frame_oe));
  c_cfg_cycle: cover property (idsel);
  c_pme_fall: cover property ($fell(pme_n));
  c_grant_wait: cover property (!req_n && gnt_n);
endmodule

`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench joining the device end to the host end.
`timescale 1ns/10ps
`default_nettype none
`include "pmw_consts.svh"

module tb_top;
  import pmw_pkg::*;
  typedef struct packed {
    pmw_word_t addr;
    pmw_nib_t cmd;
    pmw_word_t data;
    pmw_nib_t be;
  } pmw_cap_t;
  logic core_clk, reset, xfer_start, xfer_busy, xfer_done;
  pmw_word_t xfer_addr, xfer_data, power_mgmt_control_register;
  pmw_nib_t xfer_cmd, xfer_be, cfg_be, tgt_cmd, tgt_be;
  logic pm_event, wake_frame_valid, pme_clear, pme_status;
  logic network_wake_signal, cfg_start, cfg_sel, cfg_busy, cfg_done;
  pmw_word_t cfg_addr, cfg_data, tgt_addr, tgt_data;
  logic tgt_valid, pme_seen;
  int miscompares, checked, cnt;
  pmw_cap_t exp_q[$];

  pmw_bus_if i_pmw_bus_if ();
  pmw_device i_pmw_device (.core_clk(core_clk), .reset(reset),
    .bus(i_pmw_bus_if), .xfer_start(xfer_start), .xfer_addr(xfer_addr),
    .xfer_data(xfer_data), .xfer_cmd(xfer_cmd), .xfer_be(xfer_be),
    .xfer_busy(xfer_busy), .xfer_done(xfer_done), .pm_event(pm_event),
    .wake_frame_valid(wake_frame_valid), .pme_clear(pme_clear),
    .power_mgmt_control_register(power_mgmt_control_register),
    .pme_status(pme_status), .network_wake_signal(network_wake_signal));
  pmw_host i_pmw_host (.core_clk(core_clk), .reset(reset),
    .bus(i_pmw_bus_if), .cfg_start(cfg_start), .cfg_sel(cfg_sel),
    .cfg_addr(cfg_addr), .cfg_data(cfg_data), .cfg_be(cfg_be),
    .cfg_busy(cfg_busy), .cfg_done(cfg_done), .tgt_valid(tgt_valid),
    .tgt_addr(tgt_addr), .tgt_cmd(tgt_cmd), .tgt_data(tgt_data),
    .tgt_be(tgt_be), .pme_seen(pme_seen));
  pmw_bus_sva i_pmw_bus_sva (.core_clk(core_clk), .reset(reset),
    .bus_rst(i_pmw_bus_if.bus_rst), .idsel(i_pmw_bus_if.idsel),
    .gnt_n(i_pmw_bus_if.gnt_n), .req_n(i_pmw_bus_if.req_n),
    .frame_n(i_pmw_bus_if.frame_n), .irdy_n(i_pmw_bus_if.irdy_n),
    .cbe(i_pmw_bus_if.cbe), .pme_n(i_pmw_bus_if.pme_n),
    .dev_req_oe(i_pmw_bus_if.dev_req_oe),
    .dev_frame_oe(i_pmw_bus_if.dev_frame_oe),
    .dev_irdy_oe(i_pmw_bus_if.dev_irdy_oe),
    .dev_ad_oe(i_pmw_bus_if.dev_ad_oe),
    .dev_cbe_oe(i_pmw_bus_if.dev_cbe_oe),
    .dev_pme_oe(i_pmw_bus_if.dev_pme_oe),
    .host_frame_oe(i_pmw_bus_if.host_frame_oe),
    .host_ad_oe(i_pmw_bus_if.host_ad_oe));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  initial core_clk = 1'b0;
  always #12.5 core_clk = ~core_clk;

  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // A captured write with no note behind it means a refused start leaked.
  always @(negedge core_clk) begin
    if (tgt_valid === 1'b1) begin
      if (exp_q.size() == 0) check(1'b1, 1'b0);
      else check({tgt_addr, tgt_cmd, tgt_data, tgt_be},
        exp_q.pop_front());
    end
  end

  task automatic dev_xfer(input pmw_word_t a, input pmw_word_t d,
                          input pmw_nib_t c, input pmw_nib_t b, input bit dup);
    int i;
    @(negedge core_clk);
    xfer_start = 1'b1;
    xfer_addr = a;
    xfer_data = d;
    xfer_cmd = c;
    xfer_be = b;
    exp_q.push_back({a, c, d, b});
    @(negedge core_clk);
    xfer_start = 1'b0;
    check(xfer_busy, 1'b1);
    if (dup) begin
      @(negedge core_clk);
      xfer_start = 1'b1;
      xfer_data = ~d;
      @(negedge core_clk);
      xfer_start = 1'b0;
    end
    for (i = 0; i < 200 && xfer_done !== 1'b1; i++) @(negedge core_clk);
    check(xfer_done, 1'b1);
    check(xfer_busy, 1'b0);
  endtask

  task automatic cfg_wr(input logic s, input pmw_word_t a, input pmw_word_t d,
                        input pmw_nib_t b, input pmw_word_t e);
    int i;
    @(negedge core_clk);
    cfg_start = 1'b1;
    cfg_sel = s;
    cfg_addr = a;
    cfg_data = d;
    cfg_be = b;
    @(negedge core_clk);
    cfg_start = 1'b0;
    check(cfg_busy, 1'b1);
    for (i = 0; i < 200 && cfg_done !== 1'b1; i++) @(negedge core_clk);
    check(cfg_done, 1'b1);
    check(cfg_busy, 1'b0);
    check(power_mgmt_control_register, e);
  endtask

  task automatic wake_case(input pmw_word_t r, input logic p, input int n);
    int i, hi;
    cfg_wr(1'b1, 32'h48, r, 4'h0, r);
    @(negedge core_clk);
    wake_frame_valid = 1'b1;
    @(negedge core_clk);
    wake_frame_valid = 1'b0;
    hi = 0;
    for (i = 0; i < 40; i++) begin
      if (network_wake_signal === 1'b1) hi++;
      @(negedge core_clk);
    end
    check(hi, n);
    check(i_pmw_bus_if.pme_n, !p);
    check(pme_seen, p);
    pme_clear = 1'b1;
    @(negedge core_clk);
    pme_clear = 1'b0;
    check({network_wake_signal, i_pmw_bus_if.pme_n}, 2'b01);
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    #(8000 * 25);
    miscompares++;
    test_done();
  end

  initial begin
    reset = 1'b1;
    {xfer_start, pm_event, wake_frame_valid, pme_clear, cfg_start} = '0;
    {xfer_addr, xfer_data, xfer_cmd, xfer_be, cfg_sel} = '0;
    {cfg_addr, cfg_data, cfg_be} = '0;
    void'($urandom(63372));
    repeat (5) @(negedge core_clk);
    reset = 1'b0;
    repeat (3) @(negedge core_clk);
    check({i_pmw_bus_if.req_n, i_pmw_bus_if.frame_n, i_pmw_bus_if.pme_n,
           i_pmw_bus_if.ad}, {3'b111, 32'hffff_ffff});
    cnt = 3;
    while (i_pmw_bus_if.bus_rst === 1'b1 && cnt < 5000) begin
      @(negedge core_clk);
      cnt++;
    end
    check(cnt >= `PMW_RST_HOLD_CYC, 1'b1);
    check(power_mgmt_control_register, `PMW_PMCTRL_RST);
    $display("test reset done");

    for (int i = 0; i < 4; i++) begin
      dev_xfer($urandom, $urandom, 4'($urandom), 4'($urandom), i == 1);
    end
    @(negedge core_clk);
    check(exp_q.size(), 0);
    $display("test master done");

    cfg_wr(1'b1, 32'h48, 32'hffff_ffff, 4'h0, 32'h0006_0000);
    cfg_wr(1'b1, 32'h48, 32'h0, 4'h4, 32'h0006_0000);
    cfg_wr(1'b0, 32'h48, 32'h0, 4'h0, 32'h0006_0000);
    cfg_wr(1'b1, 32'h4c, 32'h0, 4'h0, 32'h0006_0000);
    cfg_wr(1'b1, 32'h48, 32'h0002_0000, 4'h0, 32'h0002_0000);
    // Both ends want the bus at once; the device must wait for the grant.
    fork
      dev_xfer($urandom, $urandom, `PMW_CMD_MEM_WR, 4'h0, 1'b0);
      cfg_wr(1'b1, 32'h48, 32'h0, 4'h0, 32'h0);
    join
    $display("test config done");

    wake_case(32'h0006_0000, 1'b1, 40);
    wake_case(32'h0004_0000, 1'b1, `PMW_WAKE_PULSE_CYC);
    wake_case(32'h0002_0000, 1'b0, 0);
    @(negedge core_clk);
    pm_event = 1'b1;
    pme_clear = 1'b1;
    @(negedge core_clk);
    pm_event = 1'b0;
    check({i_pmw_bus_if.pme_n, pme_status}, 2'b01);
    @(negedge core_clk);
    pme_clear = 1'b0;
    check({i_pmw_bus_if.pme_n, pme_seen}, 2'b11);
    $display("test wake done");
    test_done();
  end
endmodule

`default_nettype wire
